// >>> src/pcb_pkg.sv
// shared constants, layouts and types for the phase configuration command bank
package pcb_pkg;

   // command codes
   localparam logic [7:0] CMD_IDENTITY = 8'had;
   localparam logic [7:0] CMD_REVISION = 8'hae;
   localparam logic [7:0] CMD_PHASES   = 8'hd0;
   localparam logic [7:0] CMD_SHED     = 8'hd1;
   localparam logic [7:0] CMD_LIMITER  = 8'hd2;
   localparam logic [7:0] CMD_LOADLINE = 8'hd3;
   localparam logic [7:0] CMD_FEATURE  = 8'hd4;
   localparam logic [7:0] CMD_DRIVE    = 8'hd5;
   localparam logic [7:0] CMD_LOCK     = 8'hd6;
   localparam logic [7:0] CMD_RISE     = 8'hd7;

   // identity bytes, values are arbitrary
   localparam logic [7:0] PRODUCT_CODE = 8'h5a;
   localparam logic [7:0] SILICON_REV  = 8'h01;

   // phase count
   localparam int         PWM_OUTPUTS   = 6;
   localparam logic [2:0] PHASE_MAX_HW  = 3'h6;
   localparam logic [2:0] PHASE_MIN     = 3'h1;
   localparam logic [2:0] PHASE_NMAX_LO = 3'h0;
   localparam logic [2:0] PHASE_NMAX_HI = 3'h7;

   // boot refresh floor in mV
   localparam logic [11:0] BOOT_MIN_MV = 12'h25d;

   // step sizes
   localparam logic [6:0] APA_STEP_MV  = 7'h0a;
   localparam logic [8:0] RISE_STEP_MV = 9'h005;

   // dither
   localparam logic signed [5:0] DITHER_KHZ         = 6'sh0f;
   localparam int                DITHER_STEP_CYCLES = 1000;

   // output adjust lock codes
   localparam logic [1:0] LOCK_NONE  = 2'h0;
   localparam logic [1:0] LOCK_SMALL = 2'h1;
   localparam logic [1:0] LOCK_LARGE = 2'h2;
   localparam logic [1:0] LOCK_ALL   = 2'h3;

   // decode tables
   localparam logic [7:0] K_X100   [4] = '{8'h7d, 8'h96, 8'haf, 8'h64};
   localparam logic [9:0] HYS_X10  [4] = '{10'h1f4, 10'h0fa, 10'h0a6, 10'h07d};
   localparam logic [6:0] THR_PCT  [4] = '{7'h64, 7'h50, 7'h5a, 7'h6e};
   localparam logic [6:0] DROOP_PCT[8] = '{7'h64, 7'h4b, 7'h32, 7'h19,
                                          7'h05, 7'h00, 7'h00, 7'h00};
   localparam logic [5:0] POSITIVE_LOAD_LINE_RANGE_MV [4] = '{6'h04, 6'h08, 6'h10, 6'h20};

   typedef struct packed {
      logic [1:0] thr;
      logic [1:0] hys;
      logic [1:0] k;
      logic [1:0] minPh;
   } pcb_shed_t;

   typedef struct packed {
      logic [1:0] posRange;
      logic       posEn;
      logic [2:0] droopTrim;
      logic       droopEn;
   } pcb_ll_t;

   typedef struct packed {
      logic [2:0] apaLvl;
      logic       dither;
      logic       autoShed;
      logic       diodeEmu;
      logic       bootRefresh;
   } pcb_feat_t;

   typedef struct packed {
      logic       spare;
      logic       mid5v;
   } pcb_drive_t;

   typedef struct packed {
      logic [7:0] upper;
      logic [5:0] offset;
   } pcb_rise_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } pcb_cmd_t;

   typedef struct packed {
      logic [2:0]  phases;
      logic [2:0]  shedMinPhases;
      logic [7:0]  shedKX100;
      logic [9:0]  shedHysX10;
      logic [6:0]  shedThrPct;
      logic        droopEn;
      logic [6:0]  droopPct;
      logic        posLlEn;
      logic [5:0]  posLlMv;
      logic        bootRefreshOn;
      logic        diodeEmuEn;
      logic        autoShedEn;
      logic        ditherEn;
      logic        apaEn;
      logic [6:0]  apaLevelMv;
      logic        midLevel5v;
      logic        setpointProgOk;
      logic        smallOffsetOk;
      logic        largeOffsetOk;
      logic [8:0]  riseOffsetMv;
      logic [9:0]  limiterRaw;
      logic [7:0]  riseUpperRaw;
   } pcb_cfg_t;

   typedef enum logic [2:0] {
      DI_MINUS = 3'b001,
      DI_NOM   = 3'b010,
      DI_PLUS  = 3'b100
   } pcb_dith_t;

endpackage

// >>> src/pcb_dither.sv
// switching frequency dither stepper
`timescale 1ns/10ps
`default_nettype none
module pcb_dither #(
   parameter int STEP_CYCLES = pcb_pkg::DITHER_STEP_CYCLES
) (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               enable,
   output logic signed [5:0]       offsetKhz
);
   pcb_pkg::pcb_dith_t stateFf;
   pcb_pkg::pcb_dith_t nxt_state;
   logic [15:0]        cntFf;
   logic               stepNow;

   assign stepNow = (cntFf == 16'(STEP_CYCLES - 1));

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cntFf <= 16'h0000;
      end else if (ce) begin
         if (!enable || stepNow) begin
            cntFf <= 16'h0000;
         end else begin
            cntFf <= cntFf + 16'h0001;
         end
      end
   end

   // minus, nominal, plus, then back to minus
   always_comb begin
      nxt_state = stateFf;
      unique case (stateFf)
         pcb_pkg::DI_MINUS: nxt_state = pcb_pkg::DI_NOM;
         pcb_pkg::DI_NOM:   nxt_state = pcb_pkg::DI_PLUS;
         pcb_pkg::DI_PLUS:  nxt_state = pcb_pkg::DI_MINUS;
         default:           nxt_state = pcb_pkg::DI_NOM;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stateFf <= pcb_pkg::DI_NOM;
      end else if (ce) begin
         if (!enable) begin
            stateFf <= pcb_pkg::DI_NOM;
         end else if (stepNow) begin
            stateFf <= nxt_state;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         offsetKhz <= 6'sh00;
      end else if (ce) begin
         unique case (stateFf)
            pcb_pkg::DI_MINUS: offsetKhz <= -pcb_pkg::DITHER_KHZ;
            pcb_pkg::DI_PLUS:  offsetKhz <= pcb_pkg::DITHER_KHZ;
            default:           offsetKhz <= 6'sh00;
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   dither_off_a: assert property (ce && !enable ##1 ce |=> offsetKhz == 6'sh00)
      else $error("dither offset not zero while disabled");
   dither_set_a: assert property (offsetKhz == 6'sh00 || offsetKhz == pcb_pkg::DITHER_KHZ
                                  || offsetKhz == -pcb_pkg::DITHER_KHZ)
      else $error("dither offset outside the three steps");
   dither_plus_c: cover property (enable && offsetKhz == pcb_pkg::DITHER_KHZ);
endmodule
`default_nettype wire

// >>> src/pcb_bank.sv
// phase configuration command bank
// How it works
// - identity reads product code plus config revision
// - revision reads silicon code plus config revision
// - codes 0,7 mean maximum; 1-6 exact
// - first strapped output limits maximum phase count
// - auto shedding ignores writes, reads operating count
// - shed minimum phases is code plus one
// - shed K factor 1.25,1.5,1.75,1.0
// - shed hysteresis 50,25,16.6,12.5 percent
// - threshold scale 100,80,90,110 percent
// - droop enable and trim table
// - positive load line enable and range
// - boot refresh off below 0.605 V
// - diode emulation and auto shedding enables
// - dither steps minus, nominal, plus 15 kHz
// - active phase adding level, ten mV steps
// - mid level selects 3.3 V or 5 V
// - lock code gates setpoint and offsets
// - rising offset in 5 mV steps
`timescale 1ns/10ps
`default_nettype none
module pcb_bank (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire pcb_pkg::pcb_cmd_t  cmd,
   output logic                    cmdAccept,
   output logic [15:0]             rdData,
   output logic                    rdValid,
   input  wire logic [5:0]         pwmStrap,
   input  wire logic [2:0]         autoPhaseCount,
   input  wire logic [11:0]        refSetpointMv,
   input  wire logic [7:0]         cfgRevision,
   output pcb_pkg::pcb_cfg_t       cfg,
   output logic signed [5:0]       ditherOffsetKhz
);
   pcb_pkg::pcb_shed_t  shedFf;
   pcb_pkg::pcb_ll_t    llFf;
   pcb_pkg::pcb_feat_t  featFf;
   pcb_pkg::pcb_drive_t driveFf;
   pcb_pkg::pcb_rise_t  riseFf;
   pcb_pkg::pcb_cfg_t   nxt_cfg;
   logic [2:0]          phaseCodeFf;
   logic [9:0]          limiterFf;
   logic [1:0]          lockFf;
   logic [5:0]          strapS1Ff;
   logic [5:0]          strapS2Ff;
   logic [5:0]          strapS3Ff;
   logic [5:0]          strapStableFf;
   logic [2:0]          nmaxFf;
   logic [2:0]          nxt_nmax;
   logic [15:0]         nxt_rdData;
   logic                wrEn;
   logic                rdEn;
   logic                known;
   logic                readOnly;

   assign wrEn     = ce && cmd.valid && cmd.write;
   assign rdEn     = ce && cmd.valid && !cmd.write;
   assign readOnly = (cmd.code == pcb_pkg::CMD_IDENTITY) || (cmd.code == pcb_pkg::CMD_REVISION);

   always_comb begin
      unique case (cmd.code)
         pcb_pkg::CMD_IDENTITY, pcb_pkg::CMD_REVISION, pcb_pkg::CMD_PHASES,
         pcb_pkg::CMD_SHED, pcb_pkg::CMD_LIMITER, pcb_pkg::CMD_LOADLINE,
         pcb_pkg::CMD_FEATURE, pcb_pkg::CMD_DRIVE, pcb_pkg::CMD_LOCK,
         pcb_pkg::CMD_RISE: known = 1'b1;
         default:           known = 1'b0;
      endcase
   end

   // refused: unknown codes and writes to read-only commands
   assign cmdAccept = cmd.valid && known && !(cmd.write && readOnly);

   // strap pins are asynchronous; a level counts once stages two and three agree
   for (genvar i = 0; i < pcb_pkg::PWM_OUTPUTS; i++) begin : g_strap
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            strapS1Ff[i]     <= 1'b0;
            strapS2Ff[i]     <= 1'b0;
            strapS3Ff[i]     <= 1'b0;
            strapStableFf[i] <= 1'b0;
         end else if (ce) begin
            strapS1Ff[i] <= pwmStrap[i];
            strapS2Ff[i] <= strapS1Ff[i];
            strapS3Ff[i] <= strapS2Ff[i];
            if (strapS2Ff[i] == strapS3Ff[i]) begin
               strapStableFf[i] <= strapS3Ff[i];
            end
         end
      end
   end

   // lowest strapped output caps the count; never below one phase
   always_comb begin
      nxt_nmax = pcb_pkg::PHASE_MAX_HW;
      for (int i = pcb_pkg::PWM_OUTPUTS - 1; i >= 0; i--) begin
         if (strapStableFf[i]) begin
            nxt_nmax = 3'(i);
         end
      end
      if (nxt_nmax == 3'h0) begin
         nxt_nmax = pcb_pkg::PHASE_MIN;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         nmaxFf <= pcb_pkg::PHASE_MAX_HW;
      end else if (ce) begin
         nmaxFf <= nxt_nmax;
      end
   end

   // host is trusted to respect the settle time after soft-start
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         phaseCodeFf <= pcb_pkg::PHASE_NMAX_LO;
      end else if (wrEn && cmd.code == pcb_pkg::CMD_PHASES && !featFf.autoShed) begin
         phaseCodeFf <= 3'(cmd.data);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         shedFf <= '0;
      end else if (wrEn && cmd.code == pcb_pkg::CMD_SHED) begin
         shedFf <= pcb_pkg::pcb_shed_t'(8'(cmd.data));
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         limiterFf <= '0;
      end else if (wrEn && cmd.code == pcb_pkg::CMD_LIMITER) begin
         limiterFf <= 10'(cmd.data);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         llFf <= '0;
      end else if (wrEn && cmd.code == pcb_pkg::CMD_LOADLINE) begin
         llFf <= pcb_pkg::pcb_ll_t'(7'(cmd.data));
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         featFf <= '0;
      end else if (wrEn && cmd.code == pcb_pkg::CMD_FEATURE) begin
         featFf <= pcb_pkg::pcb_feat_t'(7'(cmd.data));
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         driveFf <= '0;
      end else if (wrEn && cmd.code == pcb_pkg::CMD_DRIVE) begin
         driveFf <= pcb_pkg::pcb_drive_t'(2'(cmd.data));
      end
   end

   // lock resets closed so nothing can move the output before software opens it
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lockFf <= pcb_pkg::LOCK_NONE;
      end else if (wrEn && cmd.code == pcb_pkg::CMD_LOCK) begin
         lockFf <= 2'(cmd.data);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         riseFf <= '0;
      end else if (wrEn && cmd.code == pcb_pkg::CMD_RISE) begin
         riseFf <= pcb_pkg::pcb_rise_t'(14'(cmd.data));
      end
   end

   always_comb begin
      nxt_rdData = 16'h0000;
      unique case (cmd.code)
         pcb_pkg::CMD_IDENTITY: nxt_rdData = {pcb_pkg::PRODUCT_CODE, cfgRevision};
         pcb_pkg::CMD_REVISION: nxt_rdData = {pcb_pkg::SILICON_REV, cfgRevision};
         pcb_pkg::CMD_PHASES:   nxt_rdData = featFf.autoShed ? 16'(autoPhaseCount)
                                                             : 16'(phaseCodeFf);
         pcb_pkg::CMD_SHED:     nxt_rdData = 16'(shedFf);
         pcb_pkg::CMD_LIMITER:  nxt_rdData = 16'(limiterFf);
         pcb_pkg::CMD_LOADLINE: nxt_rdData = 16'(llFf);
         pcb_pkg::CMD_FEATURE:  nxt_rdData = 16'(featFf);
         pcb_pkg::CMD_DRIVE:    nxt_rdData = 16'(driveFf);
         pcb_pkg::CMD_LOCK:     nxt_rdData = 16'(lockFf);
         pcb_pkg::CMD_RISE:     nxt_rdData = 16'(riseFf);
         default:               nxt_rdData = 16'h0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdData  <= 16'h0000;
         rdValid <= 1'b0;
      end else if (ce) begin
         rdValid <= cmd.valid && !cmd.write;
         if (cmd.valid && !cmd.write) begin
            rdData <= nxt_rdData;
         end
      end
   end

   always_comb begin
      nxt_cfg = '0;
      if (featFf.autoShed) begin
         nxt_cfg.phases = autoPhaseCount;
      end else if (phaseCodeFf == pcb_pkg::PHASE_NMAX_LO
                   || phaseCodeFf == pcb_pkg::PHASE_NMAX_HI) begin
         nxt_cfg.phases = nmaxFf;
      end else begin
         nxt_cfg.phases = phaseCodeFf;
      end
      nxt_cfg.shedMinPhases  = 3'(shedFf.minPh) + pcb_pkg::PHASE_MIN;
      nxt_cfg.shedKX100      = pcb_pkg::K_X100[shedFf.k];
      nxt_cfg.shedHysX10     = pcb_pkg::HYS_X10[shedFf.hys];
      nxt_cfg.shedThrPct     = pcb_pkg::THR_PCT[shedFf.thr];
      nxt_cfg.droopEn        = llFf.droopEn;
      nxt_cfg.droopPct       = pcb_pkg::DROOP_PCT[llFf.droopTrim];
      nxt_cfg.posLlEn        = llFf.posEn;
      nxt_cfg.posLlMv        = pcb_pkg::POSITIVE_LOAD_LINE_RANGE_MV[llFf.posRange];
      nxt_cfg.bootRefreshOn  = featFf.bootRefresh && (refSetpointMv >= pcb_pkg::BOOT_MIN_MV);
      nxt_cfg.diodeEmuEn     = featFf.diodeEmu;
      nxt_cfg.autoShedEn     = featFf.autoShed;
      nxt_cfg.ditherEn       = featFf.dither;
      nxt_cfg.apaEn          = (featFf.apaLvl != 3'h0);
      nxt_cfg.apaLevelMv     = 7'(featFf.apaLvl) * pcb_pkg::APA_STEP_MV;
      nxt_cfg.midLevel5v     = driveFf.mid5v;
      nxt_cfg.setpointProgOk = (lockFf == pcb_pkg::LOCK_ALL);
      nxt_cfg.smallOffsetOk  = (lockFf == pcb_pkg::LOCK_SMALL) || (lockFf == pcb_pkg::LOCK_ALL);
      nxt_cfg.largeOffsetOk  = (lockFf == pcb_pkg::LOCK_LARGE) || (lockFf == pcb_pkg::LOCK_ALL);
      nxt_cfg.riseOffsetMv   = 9'(riseFf.offset) * pcb_pkg::RISE_STEP_MV;
      nxt_cfg.limiterRaw     = limiterFf;
      nxt_cfg.riseUpperRaw   = riseFf.upper;
   end

   // one cycle of latency buys glitch-free configuration outputs
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfg <= '0;
      end else if (ce) begin
         cfg <= nxt_cfg;
      end
   end

   pcb_dither u_dither (
      .clock     (clock),
      .rst_n     (rst_n),
      .ce        (ce),
      .enable    (featFf.dither),
      .offsetKhz (ditherOffsetKhz)
   );

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   id_read_a: assert property (rdEn && cmd.code == pcb_pkg::CMD_IDENTITY |=> rdValid
      && rdData == {pcb_pkg::PRODUCT_CODE, $past(cfgRevision)})
      else $error("identity read wrong");
   rev_read_a: assert property (rdEn && cmd.code == pcb_pkg::CMD_REVISION |=> rdValid
      && rdData == {pcb_pkg::SILICON_REV, $past(cfgRevision)})
      else $error("revision read wrong");
   // sampled rst_n keeps the release edge, where cfg still holds reset zeros, out
   phase_nmax_a: assert property (rst_n && ce && !featFf.autoShed && (phaseCodeFf == 3'h0
      || phaseCodeFf == 3'h7) |=> cfg.phases == $past(nmaxFf))
      else $error("default phase code not mapped to maximum");
   strap_limit_a: assert property (ce && strapStableFf == 6'h20 |=> nmaxFf == 3'h5)
      else $error("sixth output strap did not limit to five phases");
   auto_write_a: assert property (wrEn && cmd.code == pcb_pkg::CMD_PHASES
      && featFf.autoShed |=> $stable(phaseCodeFf))
      else $error("phase count changed under auto shedding");
   auto_read_a: assert property (rdEn && cmd.code == pcb_pkg::CMD_PHASES && featFf.autoShed
      |=> rdData == 16'($past(autoPhaseCount)))
      else $error("auto shedding read not operating count");
   shed_min_a: assert property (rst_n && ce |=> cfg.shedMinPhases
      == $past(3'(shedFf.minPh)) + 3'h1)
      else $error("shed minimum wrong");
   shed_k_a: assert property (ce && shedFf.k == 2'h3 |=> cfg.shedKX100 == 8'h64)
      else $error("K factor code 3 not 1.0");
   shed_hys_a: assert property (ce && shedFf.hys == 2'h2 |=> cfg.shedHysX10 == 10'h0a6)
      else $error("hysteresis code 2 wrong");
   shed_thr_a: assert property (ce && shedFf.thr == 2'h1 |=> cfg.shedThrPct == 7'h50)
      else $error("threshold code 1 wrong");
   droop_trim_a: assert property (ce && llFf.droopTrim == 3'h4 |=> cfg.droopPct == 7'h05)
      else $error("droop trim code 4 wrong");
   positive_load_line_range_range_a: assert property (rst_n && ce |=> cfg.posLlEn == $past(llFf.posEn)
      && cfg.posLlMv == (6'h04 << $past(llFf.posRange)))
      else $error("positive load line wrong");
   boot_floor_a: assert property (ce && refSetpointMv < 12'h25d |=> !cfg.bootRefreshOn)
      else $error("boot refresh on below floor");
   feat_en_a: assert property (ce |=> cfg.diodeEmuEn == $past(featFf.diodeEmu)
      && cfg.autoShedEn == $past(featFf.autoShed))
      else $error("feature enables wrong");
   apa_level_a: assert property (ce |=> cfg.apaEn == ($past(featFf.apaLvl) != 3'h0)
      && cfg.apaLevelMv == 7'($past(featFf.apaLvl)) * 7'h0a)
      else $error("phase adding level wrong");
   drive_mid_a: assert property (ce |=> cfg.midLevel5v == $past(driveFf.mid5v))
      else $error("mid level select wrong");
   lock_gate_a: assert property (ce && lockFf == 2'h1 |=> cfg.smallOffsetOk
      && !cfg.largeOffsetOk && !cfg.setpointProgOk)
      else $error("small offset lock wrong");
   rise_step_a: assert property (ce |=> cfg.riseOffsetMv
      == 9'($past(riseFf.offset)) * 9'h005)
      else $error("rising offset wrong");
   ro_write_a: assert property (cmd.valid && cmd.write && readOnly |-> !cmdAccept)
      else $error("read-only write accepted");

   auto_write_c: cover property (wrEn && cmd.code == pcb_pkg::CMD_PHASES && featFf.autoShed);
   strap_cap_c:  cover property (nmaxFf == 3'h5);
   lock_open_c:  cover property (cfg.setpointProgOk);
endmodule
`default_nettype wire

// >>> tb/pcb_host.sv
// management bus host model driving the command port
`timescale 1ns/10ps
`default_nettype none
module pcb_host (
   input  wire logic              clock,
   output pcb_pkg::pcb_cmd_t      cmd,
   input  wire logic              cmdAccept,
   input  wire logic [15:0]       rdData,
   input  wire logic              rdValid
);
   initial cmd = '0;

   // one command per call, held until the taking edge
   // phase count writes are issued whole and repeated by the caller when needed
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                       output logic acc, output logic [15:0] rd);
      @(posedge clock);
      cmd <= '{valid: 1'b1, write: wr, code: code, data: data};
      #1 acc = cmdAccept;
      @(posedge clock);
      // released lines show the inverse so stale data never passes
      cmd <= '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
      #1 rd = (rdValid === 1'b1) ? rdData : 16'hxxxx;
   endtask
endmodule
`default_nettype wire

// >>> tb/pcb_bank_test.sv
// self-checking bench for the phase configuration command bank
`timescale 1ns/10ps
`default_nettype none
module pcb_bank_test;
   logic              clock;
   logic              rst_n;
   logic              ce;
   pcb_pkg::pcb_cmd_t cmd;
   logic              cmdAccept;
   logic [15:0]       rdData;
   logic              rdValid;
   logic [5:0]        pwmStrap;
   logic [2:0]        autoPhaseCount;
   logic [11:0]       refSetpointMv;
   logic [7:0]        cfgRevision;
   pcb_pkg::pcb_cfg_t cfg;
   logic signed [5:0] ditherOffsetKhz;
   int                error_cnt = 0;
   int                num_checks = 0;
   int                cycles = 0;
   logic [31:0]       seed = 32'hddb5;
   logic              acc;
   logic [15:0]       rd;
   logic [15:0]       d;
   logic [7:0]        c;
   logic [15:0]       kt [4] = '{16'h007d, 16'h0096, 16'h00af, 16'h0064};
   logic [15:0]       ht [4] = '{16'h01f4, 16'h00fa, 16'h00a6, 16'h007d};
   logic [15:0]       tt [4] = '{16'h0064, 16'h0050, 16'h005a, 16'h006e};
   logic [6:0]        dt [8] = '{7'h64, 7'h4b, 7'h32, 7'h19, 7'h05, 7'h00, 7'h00, 7'h00};
   logic [5:0]        pt [4] = '{6'h04, 6'h08, 6'h10, 6'h20};

   pcb_bank u_dut (.clock(clock), .rst_n(rst_n), .ce(ce), .cmd(cmd),
      .cmdAccept(cmdAccept), .rdData(rdData), .rdValid(rdValid), .pwmStrap(pwmStrap),
      .autoPhaseCount(autoPhaseCount), .refSetpointMv(refSetpointMv),
      .cfgRevision(cfgRevision), .cfg(cfg), .ditherOffsetKhz(ditherOffsetKhz));

   pcb_host u_host (.clock(clock), .cmd(cmd), .cmdAccept(cmdAccept), .rdData(rdData),
      .rdValid(rdValid));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [15:0] wmask(input logic [7:0] code);
      case (code)
         8'hd1: return 16'h00ff;
         8'hd2: return 16'h03ff;
         8'hd3, 8'hd4: return 16'h007f;
         8'hd5, 8'hd6: return 16'h0003;
         default: return 16'h3fff;
      endcase
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      u_host.xfer(1'b1, code, data, acc, rd);
   endtask

   task automatic rdr(input logic [7:0] code);
      u_host.xfer(1'b0, code, 16'h0000, acc, rd);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // decoded outputs, one edge after the register takes the write
   task automatic cfg_check(input logic [7:0] code, input logic [15:0] v);
      case (code)
         8'hd1: begin
            check({13'h0, cfg.shedMinPhases}, {14'h0, v[1:0]} + 16'h0001);
            check({8'h0, cfg.shedKX100}, kt[v[3:2]]);
            check({6'h0, cfg.shedHysX10}, ht[v[5:4]]);
            check({9'h0, cfg.shedThrPct}, tt[v[7:6]]);
         end
         8'hd2: check({6'h0, cfg.limiterRaw}, v & 16'h03ff);
         8'hd3: begin
            check({8'h0, cfg.droopEn, cfg.droopPct}, {8'h0, v[0], dt[v[3:1]]});
            check({9'h0, cfg.posLlEn, cfg.posLlMv}, {9'h0, v[4], pt[v[6:5]]});
         end
         8'hd4: check({5'h0, cfg.diodeEmuEn, cfg.autoShedEn, cfg.ditherEn, cfg.apaEn,
            cfg.apaLevelMv}, {5'h0, v[1], v[2], v[3], v[6:4] != 3'h0,
            {4'h0, v[6:4]} * 7'h0a});
         8'hd5: check({15'h0, cfg.midLevel5v}, {15'h0, v[0]});
         8'hd6: check({13'h0, cfg.setpointProgOk, cfg.smallOffsetOk, cfg.largeOffsetOk},
            {13'h0, v[1:0] == 2'h3, v[0], v[1]});
         8'hd7: begin
            check({7'h0, cfg.riseOffsetMv}, {10'h0, v[5:0]} * 16'h0005);
            check({8'h0, cfg.riseUpperRaw}, {8'h0, v[13:6]});
         end
         default: ;
      endcase
   endtask

   // ceiling well above the roughly 2900 cycles the run needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         error_cnt++;
         end_of_test();
      end
   end

   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      pwmStrap = 6'h00;
      autoPhaseCount = 3'h0;
      refSetpointMv = 12'h000;
      cfgRevision = 8'h00;
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      tick(1);
      for (int i = 0; i < 8; i++) begin
         rdr(8'hd0 + 8'(i));
         check(rd, 16'h0000);
      end
      $display("done: reset values");
      for (int i = 0; i < 40; i++) begin
         seed = lfsr(seed);
         c = 8'hd1 + 8'(seed[18:16] % 3'h7);
         d = (c == 8'hd4) ? (seed[15:0] & 16'hfffb) : seed[15:0];
         @(posedge clock);
         autoPhaseCount <= seed[22:20];
         refSetpointMv <= seed[31:20];
         wr(c, d);
         check({15'h0, acc}, 16'h0001);
         tick(1);
         cfg_check(c, d);
         rdr(c);
         check(rd, d & wmask(c));
      end
      for (int i = 0; i < 4; i++) begin
         wr(8'hd6, 16'(i));
         tick(1);
         cfg_check(8'hd6, 16'(i));
      end
      $display("done: random writes");
      @(posedge clock);
      cfgRevision <= seed[7:0];
      wr(8'had, 16'hffff);
      check({15'h0, acc}, 16'h0000);
      wr(8'hae, 16'hffff);
      check({15'h0, acc}, 16'h0000);
      rdr(8'had);
      check(rd, {pcb_pkg::PRODUCT_CODE, seed[7:0]});
      rdr(8'hae);
      check(rd, {pcb_pkg::SILICON_REV, seed[7:0]});
      rdr(8'h00);
      check(rd, 16'h0000);
      check({15'h0, acc}, 16'h0000);
      // a write made while the clock enable is low must not land
      wr(8'hd5, 16'h0000);
      ce <= 1'b0;
      wr(8'hd5, 16'h0001);
      ce <= 1'b1;
      rdr(8'hd5);
      check(rd, 16'h0000);
      $display("done: identity");
      for (int i = 0; i < 8; i++) begin
         wr(8'hd0, 16'(i));
         tick(1);
         check({13'h0, cfg.phases}, (i == 0 || i == 7) ? 16'h0006 : 16'(i));
      end
      @(posedge clock);
      pwmStrap <= 6'h20;
      tick(8);
      wr(8'hd0, 16'h0000);
      tick(1);
      check({13'h0, cfg.phases}, 16'h0005);
      wr(8'hd4, 16'h0004);
      @(posedge clock);
      autoPhaseCount <= 3'h2;
      wr(8'hd0, 16'h0003);
      rdr(8'hd0);
      check(rd, 16'h0002);
      wr(8'hd4, 16'h0000);
      rdr(8'hd0);
      check(rd, 16'h0000);
      $display("done: phase count");
      wr(8'hd4, 16'h0001);
      @(posedge clock);
      refSetpointMv <= 12'h25c;
      tick(3);
      check({15'h0, cfg.bootRefreshOn}, 16'h0000);
      refSetpointMv <= 12'h25d;
      tick(3);
      check({15'h0, cfg.bootRefreshOn}, 16'h0001);
      $display("done: boot refresh");
      // mid-step samples keep the check clear of the exact step edge
      wr(8'hd4, 16'h0008);
      tick(500);
      check({10'h0, ditherOffsetKhz}, 16'h0000);
      tick(1000);
      check({10'h0, ditherOffsetKhz}, 16'h000f);
      tick(1000);
      check({10'h0, ditherOffsetKhz}, 16'h0031);
      wr(8'hd4, 16'h0000);
      tick(3);
      check({10'h0, ditherOffsetKhz}, 16'h0000);
      $display("done: dither");
      end_of_test();
   end
endmodule
`default_nettype wire
